/* File: half_duplex_poll_master_test.sv */
// Purpose: self-checking bench of the poll master
// Assumes: no handshake beyond a short full-duplex rts check, cts tied high
// Notes: a queue of expected reads and frames
`timescale 1ns/1ps
module half_duplex_poll_master_test;
   logic i_clock = 0, i_nrst = 0, i_wr = 0, i_rd = 0, rd_d = 0, i_cts = 1;
   logic [3:0] i_addr = 0;
   logic [31:0] i_wdata = 0, o_rdata, exp_q[$];
   logic o_tx_valid, i_tx_done, i_rx_valid, i_rx_cmd, o_cmd_valid, o_rts, o_bit_tick;
   hdpm_pkg::hdpm_pkt_t o_tx_kind;
   hdpm_pkg::hdpm_rx_t i_rx_kind;
   logic [7:0] o_tx_dest, o_tx_src, i_rx_dest, i_rx_src, o_cmd_src, stn;
   logic [15:0] i_rx_sig;
   int miscompares = 0, samples_checked = 0, gap = 0;
   always #50 i_clock = ~i_clock;
   hdpm_master #(.P_TICK_CYCLES(20), .P_BIT_MIN_CYCLES(1024)) dut_u (.i_clock, .i_nrst,
      .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_tx_valid, .o_tx_kind, .o_tx_dest,
      .o_tx_src, .i_tx_done, .i_rx_valid, .i_rx_kind, .i_rx_dest, .i_rx_src, .i_rx_cmd,
      .i_rx_sig, .o_cmd_valid, .o_cmd_src, .i_cts, .o_rts, .o_bit_tick);
   hdpm_slave_model slv_u (.i_clock, .i_nrst, .i_tx_valid(o_tx_valid), .i_tx_kind(o_tx_kind),
      .i_tx_dest(o_tx_dest), .i_fwd_src(8'h04), .i_fwd_dst(8'h14), .o_tx_done(i_tx_done),
      .o_rx_valid(i_rx_valid), .o_rx_cmd(i_rx_cmd), .o_rx_kind(i_rx_kind),
      .o_rx_dest(i_rx_dest), .o_rx_src(i_rx_src), .o_rx_sig(i_rx_sig));
   function automatic logic [31:0] pk(input logic [1:0] k, input logic [7:0] s, d);
      return {14'h0, k, s, d};
   endfunction : pk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clock);
      {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      @(posedge i_clock);
      {i_rd, i_addr} <= {1'b1, a};
      @(posedge i_clock);
      i_rd <= 1'b0;
   endtask : rd
   task automatic cmp(input string nm, input logic [31:0] e, seen);
      samples_checked++;
      if (e !== seen) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, seen);
      end
   endtask : cmp
   task automatic check(input string nm, input logic [31:0] seen);
      if (exp_q.size() != 0) begin
         cmp(nm, exp_q.pop_front(), seen);
      end else begin
         // nothing was due, so any result is a mismatch, unknowns included
         miscompares++;
         $display("Error %s expected none seen %h", nm, seen);
      end
   endtask : check
   task automatic complete_run();
      if (exp_q.size() != 0) miscompares++;
      $display("checked %0d mismatched %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   always @(posedge i_clock) begin
      if (rd_d) check("rdata", o_rdata);
      if (o_tx_valid && i_tx_done) begin
         check("frame", pk(o_tx_kind, o_tx_src, o_tx_dest));
         cmp("rts", 32'h0, {31'h0, o_rts});
         cmp("cmd_valid", 32'h0, {31'h0, o_cmd_valid});
      end
      // bit period at 19200 baud, with 1024 cycles standing for one bit at 300 baud
      if (o_bit_tick && gap > 0) cmp("bit_period", 1024 / (19200 / 300), gap);
      if (o_bit_tick || gap > 0) gap = o_bit_tick ? 1 : gap + 1;
      rd_d = i_rd;
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      miscompares++;
      complete_run();
   end
   initial begin
      void'($urandom(99));
      stn = 8'h30 + 8'($urandom % 64);
      repeat (3) @(posedge i_clock);
      i_nrst <= 1'b1;
      rd(hdpm_pkg::REG_CTRL, 32'hd0);
      rd(hdpm_pkg::REG_STATION, 32'h01);
      rd(hdpm_pkg::REG_RTSOFF, 32'h0);
      rd(4'h9, 32'h0);
      wr(hdpm_pkg::REG_STATION, {24'h0, stn});
      wr(hdpm_pkg::REG_STATION, 32'hff);
      rd(hdpm_pkg::REG_STATION, {24'h0, stn});
      wr(hdpm_pkg::REG_CTRL, 32'hd8);
      repeat (3) @(posedge i_clock);
      cmp("rts_full", 32'h1, {31'h0, o_rts});
      wr(hdpm_pkg::REG_CTRL, 32'hd0);
      repeat (100) @(posedge i_clock); // any frame here is unexpected
      $display("test registers done");
      for (int s = 0; s < 2; s++) begin
         for (int a = 3; a <= 5; a++) begin
            exp_q.push_back(pk(hdpm_pkg::HDPM_PKT_POLL, stn, 8'(a)));
            if (s == 0 && a == 4) exp_q.push_back(pk(hdpm_pkg::HDPM_PKT_FWD, 8'h04, 8'h14));
         end
         for (int k = 0; k < 2; k++) exp_q.push_back(pk(0, stn, 8'(10 + (2 * s + k) % 3)));
      end
      wr(hdpm_pkg::REG_PRI, 32'h0503);
      wr(hdpm_pkg::REG_NRM, 32'h020c0a);
      for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge i_clock);
      $display("test poll scan done");
      complete_run();
   end
endmodule : half_duplex_poll_master_test

/* File: hdpm_div.sv */
// Purpose: free-running divider giving a one-cycle enable every i_period cycles
// Assumes: i_period of at least 1
// Notes: a period change applies to the count in progress, which wraps at once if already past it
`timescale 1ns/1ps
module hdpm_div #(
   parameter int W = 16
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [W-1:0] i_period,
   output logic o_tick
);
   logic [W-1:0] cnt;

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         cnt <= '0;
         o_tick <= 1'b0;
      end else if (cnt >= W'(i_period - 1'b1)) begin
         cnt <= '0;
         o_tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         o_tick <= 1'b0;
      end
   end
endmodule : hdpm_div

/* File: hdpm_master.sv */
// Purpose: poll scheduler and link control of a half-duplex multidrop master
// Assumes: same-clock packet framer on the tx/rx ports; cts arrives from a pin
// Notes: packet contents are the framer's; this block decides what goes out when
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module hdpm_master #(
   parameter int P_TICK_CYCLES = hdpm_pkg::TICK_CYCLES,
   parameter int P_BIT_MIN_CYCLES = hdpm_pkg::BIT_MIN_CYCLES
) (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   output logic o_tx_valid,
   output hdpm_pkg::hdpm_pkt_t o_tx_kind,
   output logic [7:0] o_tx_dest,
   output logic [7:0] o_tx_src,
   input wire logic i_tx_done,
   input wire logic i_rx_valid,
   input wire hdpm_pkg::hdpm_rx_t i_rx_kind,
   input wire logic [7:0] i_rx_dest,
   input wire logic [7:0] i_rx_src,
   input wire logic i_rx_cmd,
   input wire logic [15:0] i_rx_sig,
   output logic o_cmd_valid,
   output logic [7:0] o_cmd_src,
   input wire logic i_cts,
   output logic o_rts,
   output logic o_bit_tick
);
   typedef enum logic [1:0] {ST_NEXT, ST_SEND, ST_WAIT, ST_DELAY} hdpm_state_t;
   hdpm_state_t state;
   hdpm_pkg::hdpm_pkt_t tx_kind;
   logic [7:0] ctrl, station, pri_lo, pri_hi, nrm_lo, nrm_hi, group;
   logic [7:0] ack_to, reply_to, retries, msg_dest, retry_cnt;
   logic [7:0] tx_dest, tx_src, poll_addr, pri_ptr, nrm_ptr, grp_cnt, nrm_cur;
   logic [15:0] rts_off, last_sig;
   logic msg_pend, st_done, st_fail, st_dup, last_ok;
   logic again, reply_poll, scan_new, phase_nrm, pick_pri, pick_nrm;
   logic cts_meta, cts_sync, cts_ok, tick, tmr_exp, rts_busy;
   logic [1:0] mode, hs;
   logic std, multi, allow, dup_en;
   logic rx_poll, rx_msg, rx_dup, rx_drop, rx_mine, ack_ok, miss;
   logic ev_done, ev_fail, tmr_load, rts_load, msg_take;
   logic [15:0] tmr_val;

   assign mode = ctrl[hdpm_pkg::CTRL_MODE_LSB +: 2];
   assign hs = ctrl[hdpm_pkg::CTRL_HS_LSB +: 2];
   assign dup_en = ctrl[hdpm_pkg::CTRL_DUP_BIT];
   assign std = (mode == hdpm_pkg::MODE_STD_SINGLE) || (mode == hdpm_pkg::MODE_STD_MULTI);
   assign multi = (mode == hdpm_pkg::MODE_STD_MULTI);
   assign allow = (mode == hdpm_pkg::MODE_MSG_ALLOW);

   hdpm_div #(.W(18)) u_tick (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_period(18'(P_TICK_CYCLES)),
      .o_tick(tick)
   );

   // rates are 300 baud doubled per code step, so a shift replaces a table
   hdpm_div #(.W(16)) u_baud (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_period(16'(P_BIT_MIN_CYCLES >> ctrl[hdpm_pkg::CTRL_BAUD_LSB +: 3])),
      .o_tick(o_bit_tick)
   );

   hdpm_timer u_resp_tmr (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_load(tmr_load),
      .i_value(tmr_val),
      .i_tick(tick),
      .o_busy(),
      .o_expire(tmr_exp)
   );

   hdpm_timer u_rts_tmr (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_load(rts_load),
      .i_value(rts_off),
      .i_tick(tick),
      .o_busy(rts_busy),
      .o_expire()
   );

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         cts_meta <= 1'b0;
         cts_sync <= 1'b0;
      end else begin
         cts_meta <= i_cts;
         cts_sync <= cts_meta;
      end
   end

   always_comb begin
      cts_ok = (hs != hdpm_pkg::HS_HALF) || cts_sync;
      o_tx_valid = (state == ST_SEND) && cts_ok;
      rx_poll = (state == ST_WAIT) && (tx_kind == hdpm_pkg::HDPM_PKT_POLL) && i_rx_valid;
      rx_msg = rx_poll && (i_rx_kind == hdpm_pkg::HDPM_RX_MSG);
      rx_dup = rx_msg && dup_en && last_ok && (i_rx_sig == last_sig);
      rx_drop = rx_dup || (rx_msg && !std && !allow && i_rx_cmd);
      rx_mine = rx_msg && !rx_drop && (i_rx_dest == station);
      ack_ok = (state == ST_WAIT) && i_rx_valid && (tx_kind != hdpm_pkg::HDPM_PKT_POLL)
         && (i_rx_kind == hdpm_pkg::HDPM_RX_ACK);
      miss = (state == ST_WAIT) && ((tmr_exp && !i_rx_valid) || (i_rx_valid
         && (tx_kind != hdpm_pkg::HDPM_PKT_POLL) && (i_rx_kind == hdpm_pkg::HDPM_RX_NAK)));
      tmr_load = (o_tx_valid && i_tx_done) || (ack_ok && tx_kind == hdpm_pkg::HDPM_PKT_MSG && !std);
      tmr_val = {8'h00, (state == ST_WAIT) ? reply_to : ack_to};
      rts_load = o_tx_valid && i_tx_done && (hs == hdpm_pkg::HS_HALF);
      msg_take = (state == ST_NEXT) && msg_pend;
      ev_done = (ack_ok && tx_kind == hdpm_pkg::HDPM_PKT_MSG && std) || (rx_mine && !i_rx_cmd);
      ev_fail = (miss && tx_kind == hdpm_pkg::HDPM_PKT_MSG && retry_cnt >= retries)
         || (reply_poll && ((rx_poll && i_rx_kind == hdpm_pkg::HDPM_RX_EMPTY) || miss));
      nrm_cur = (nrm_ptr < nrm_lo || nrm_ptr > nrm_hi) ? nrm_lo : nrm_ptr;
   end

   assign o_tx_kind = tx_kind;
   assign o_tx_dest = tx_dest;
   assign o_tx_src = tx_src;

   // poll scheduler and transaction sequencer; only one packet is ever in flight
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         state <= ST_NEXT;
         tx_kind <= hdpm_pkg::HDPM_PKT_POLL;
         tx_dest <= 8'h00;
         tx_src <= 8'h00;
         poll_addr <= 8'h00;
         retry_cnt <= 8'h00;
         again <= 1'b0;
         reply_poll <= 1'b0;
         scan_new <= 1'b1;
         phase_nrm <= 1'b0;
         pri_ptr <= 8'h00;
         nrm_ptr <= 8'h00;
         grp_cnt <= 8'h00;
         pick_pri <= 1'b0;
         pick_nrm <= 1'b0;
      end else begin
         pick_pri <= 1'b0;
         pick_nrm <= 1'b0;
         case (state)
            ST_NEXT: begin
               retry_cnt <= 8'h00;
               reply_poll <= 1'b0;
               tx_src <= station;
               if (msg_pend) begin
                  tx_kind <= hdpm_pkg::HDPM_PKT_MSG;
                  tx_dest <= msg_dest;
                  state <= ST_SEND;
               end else if (!std) begin
                  state <= ST_NEXT;
               end else if (again) begin
                  again <= 1'b0;
                  tx_kind <= hdpm_pkg::HDPM_PKT_POLL;
                  tx_dest <= poll_addr;
                  state <= ST_SEND;
               end else if (scan_new) begin
                  scan_new <= 1'b0;
                  phase_nrm <= 1'b0;
                  pri_ptr <= pri_lo;
                  grp_cnt <= 8'h00;
               end else if (!phase_nrm) begin
                  if (pri_lo == hdpm_pkg::RANGE_OFF || pri_ptr > pri_hi
                     || pri_ptr == hdpm_pkg::RANGE_OFF) begin
                     phase_nrm <= 1'b1;
                  end else begin
                     tx_kind <= hdpm_pkg::HDPM_PKT_POLL;
                     tx_dest <= pri_ptr;
                     poll_addr <= pri_ptr;
                     pri_ptr <= pri_ptr + 8'h01;
                     pick_pri <= 1'b1;
                     state <= ST_SEND;
                  end
               end else if (nrm_lo == hdpm_pkg::RANGE_OFF || grp_cnt >= group) begin
                  scan_new <= 1'b1;
               end else begin
                  tx_kind <= hdpm_pkg::HDPM_PKT_POLL;
                  tx_dest <= nrm_cur;
                  poll_addr <= nrm_cur;
                  nrm_ptr <= (nrm_cur >= nrm_hi) ? nrm_lo : nrm_cur + 8'h01;
                  grp_cnt <= grp_cnt + 8'h01;
                  pick_nrm <= 1'b1;
                  state <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (o_tx_valid && i_tx_done) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (rx_poll && i_rx_kind == hdpm_pkg::HDPM_RX_EMPTY) begin
                  again <= 1'b0;
                  state <= ST_NEXT;
               end else if (rx_msg) begin
                  again <= multi;
                  state <= ST_NEXT;
                  retry_cnt <= 8'h00;
                  if (rx_drop) begin
                     state <= ST_NEXT;
                  end else if (i_rx_dest == station) begin
                     if (i_rx_cmd) begin
                        tx_kind <= hdpm_pkg::HDPM_PKT_REPLY;
                        tx_dest <= i_rx_src;
                        state <= ST_SEND;
                     end
                  end else begin
                     tx_kind <= hdpm_pkg::HDPM_PKT_FWD;
                     tx_dest <= i_rx_dest;
                     tx_src <= i_rx_src;
                     state <= ST_SEND;
                  end
               end else if (ack_ok) begin
                  state <= (tx_kind == hdpm_pkg::HDPM_PKT_MSG && !std) ? ST_DELAY : ST_NEXT;
               end else if (miss) begin
                  if (tx_kind != hdpm_pkg::HDPM_PKT_POLL && retry_cnt < retries) begin
                     retry_cnt <= retry_cnt + 8'h01;
                     state <= ST_SEND;
                  end else begin
                     again <= 1'b0;
                     state <= ST_NEXT;
                  end
               end
            end
            ST_DELAY: begin
               if (tmr_exp) begin
                  tx_kind <= hdpm_pkg::HDPM_PKT_POLL;
                  reply_poll <= 1'b1;
                  state <= ST_SEND;
               end
            end
            default: state <= ST_NEXT;
         endcase
      end
   end

   // duplicates are judged against the last non-duplicate message response only, dropped commands included
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         last_sig <= 16'h0000;
         last_ok <= 1'b0;
         o_cmd_valid <= 1'b0;
         o_cmd_src <= 8'h00;
      end else begin
         o_cmd_valid <= rx_mine && i_rx_cmd;
         if (rx_mine && i_rx_cmd) begin
            o_cmd_src <= i_rx_src;
         end
         if (rx_msg && !rx_dup) begin
            last_sig <= i_rx_sig;
            last_ok <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_rts <= 1'b0;
      end else begin
         case (hs)
            hdpm_pkg::HS_HALF: o_rts <= (state == ST_SEND) || rts_busy || rts_load;
            hdpm_pkg::HS_FULL: o_rts <= 1'b1;
            hdpm_pkg::HS_485: o_rts <= (state == ST_SEND);
            default: o_rts <= 1'b0;
         endcase
      end
   end

   // register writes; hardware sets win over software clears
   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         ctrl <= hdpm_pkg::CTRL_RST;
         station <= hdpm_pkg::STATION_RST;
         pri_lo <= hdpm_pkg::RANGE_LO_RST;
         pri_hi <= hdpm_pkg::RANGE_HI_RST;
         nrm_lo <= hdpm_pkg::RANGE_LO_RST;
         nrm_hi <= hdpm_pkg::RANGE_HI_RST;
         group <= hdpm_pkg::GROUP_RST;
         ack_to <= hdpm_pkg::ACK_RST;
         reply_to <= hdpm_pkg::REPLY_RST;
         retries <= hdpm_pkg::RETRY_RST;
         rts_off <= hdpm_pkg::RTSOFF_RST;
         msg_dest <= 8'h00;
         msg_pend <= 1'b0;
         st_done <= 1'b0;
         st_fail <= 1'b0;
         st_dup <= 1'b0;
      end else begin
         if (i_wr && i_addr == hdpm_pkg::REG_CTRL) begin
            ctrl <= i_wdata[hdpm_pkg::CTRL_W-1:0];
         end else if (i_wr && i_addr == hdpm_pkg::REG_STATION) begin
            if (i_wdata[7:0] != hdpm_pkg::ADDR_BROADCAST) begin
               station <= i_wdata[7:0];
            end
         end else if (i_wr && i_addr == hdpm_pkg::REG_PRI) begin
            pri_lo <= i_wdata[hdpm_pkg::LO_LSB +: 8];
            pri_hi <= i_wdata[hdpm_pkg::HI_LSB +: 8];
         end else if (i_wr && i_addr == hdpm_pkg::REG_NRM) begin
            nrm_lo <= i_wdata[hdpm_pkg::LO_LSB +: 8];
            nrm_hi <= i_wdata[hdpm_pkg::HI_LSB +: 8];
            group <= i_wdata[hdpm_pkg::GROUP_LSB +: 8];
         end else if (i_wr && i_addr == hdpm_pkg::REG_TIMING) begin
            ack_to <= i_wdata[hdpm_pkg::ACK_LSB +: 8];
            reply_to <= i_wdata[hdpm_pkg::REPLY_LSB +: 8];
            retries <= i_wdata[hdpm_pkg::RETRY_LSB +: 8];
         end else if (i_wr && i_addr == hdpm_pkg::REG_RTSOFF) begin
            rts_off <= i_wdata[15:0];
         end
         if (i_wr && i_addr == hdpm_pkg::REG_MSGREQ) begin
            msg_dest <= i_wdata[7:0];
         end
         msg_pend <= (i_wr && i_addr == hdpm_pkg::REG_MSGREQ) || (msg_pend && !msg_take);
         st_done <= ev_done || (st_done && !(i_wr && i_addr == hdpm_pkg::REG_STATUS
            && i_wdata[hdpm_pkg::ST_DONE_BIT]));
         st_fail <= ev_fail || (st_fail && !(i_wr && i_addr == hdpm_pkg::REG_STATUS
            && i_wdata[hdpm_pkg::ST_FAIL_BIT]));
         st_dup <= rx_dup || (st_dup && !(i_wr && i_addr == hdpm_pkg::REG_STATUS
            && i_wdata[hdpm_pkg::ST_DUP_BIT]));
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         o_rdata <= 32'h0000_0000;
      end else if (!i_rd) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_addr == hdpm_pkg::REG_CTRL) begin
         o_rdata <= {24'h000000, ctrl};
      end else if (i_addr == hdpm_pkg::REG_STATION) begin
         o_rdata <= {24'h000000, station};
      end else if (i_addr == hdpm_pkg::REG_PRI) begin
         o_rdata <= {16'h0000, pri_hi, pri_lo};
      end else if (i_addr == hdpm_pkg::REG_NRM) begin
         o_rdata <= {8'h00, group, nrm_hi, nrm_lo};
      end else if (i_addr == hdpm_pkg::REG_TIMING) begin
         o_rdata <= {8'h00, retries, reply_to, ack_to};
      end else if (i_addr == hdpm_pkg::REG_RTSOFF) begin
         o_rdata <= {16'h0000, rts_off};
      end else if (i_addr == hdpm_pkg::REG_STATUS) begin
         o_rdata <= {19'h00000, st_dup, st_fail, st_done, msg_pend, phase_nrm, poll_addr};
      end else if (i_addr == hdpm_pkg::REG_MSGREQ) begin
         o_rdata <= {23'h000000, msg_pend, msg_dest};
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   AST_PRI_IN_RANGE: assert property (@(posedge i_clock) disable iff (!i_nrst)
      pick_pri |-> (pri_lo != 8'hff) && (tx_dest >= pri_lo) && (tx_dest <= pri_hi))
      else $error("priority poll outside range");
   AST_GROUP_LIMIT: assert property (@(posedge i_clock) disable iff (!i_nrst)
      pick_nrm |-> (grp_cnt <= group) && (grp_cnt != 8'h00) && (nrm_lo != 8'hff))
      else $error("normal group size exceeded");
   AST_MSG_MODE_QUIET: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (state == ST_NEXT && !std && !msg_pend) |=> (state == ST_NEXT) && !o_tx_valid)
      else $error("message mode sent without request");
   AST_ONE_OUTSTANDING: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (o_tx_valid && i_tx_done) |=> (state == ST_WAIT) && !o_tx_valid)
      else $error("second packet before answer");
   AST_FORWARD: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (rx_msg && !rx_drop && i_rx_dest != station) |=>
      (state == ST_SEND) && (tx_kind == hdpm_pkg::HDPM_PKT_FWD) && (tx_dest == $past(i_rx_dest)))
      else $error("foreign message not forwarded");
   AST_REPLY: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (rx_mine && i_rx_cmd) |=> o_cmd_valid && (tx_kind == hdpm_pkg::HDPM_PKT_REPLY)
      && (tx_dest == o_cmd_src))
      else $error("command not answered");
   AST_DUP_DROP: assert property (@(posedge i_clock) disable iff (!i_nrst)
      rx_dup |=> (state == ST_NEXT) && !o_cmd_valid && st_dup)
      else $error("duplicate not discarded");
   AST_STATION_GUARD: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (i_wr && i_addr == hdpm_pkg::REG_STATION && i_wdata[7:0] == 8'hff) |=>
      (station == $past(station)))
      else $error("broadcast accepted as station");
   AST_RTS_HOLD: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (rts_load && rts_off != 16'h0000) |=> o_rts ##1 o_rts)
      else $error("rts dropped early");
   AST_RETRY: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (miss && tx_kind != hdpm_pkg::HDPM_PKT_POLL && retry_cnt < retries) |=>
      (state == ST_SEND) && (retry_cnt == $past(retry_cnt) + 8'h01))
      else $error("retry not sent");
   AST_FULL_RTS: assert property (@(posedge i_clock) disable iff (!i_nrst)
      (hs == hdpm_pkg::HS_FULL) ##1 (hs == hdpm_pkg::HS_FULL) |-> o_rts)
      else $error("rts not held in full duplex");
endmodule : hdpm_master

/* File: hdpm_pkg.sv */
// Purpose: shared constants and encodings of the half-duplex poll master
// Assumes: 10 MHz system clock, word-indexed register port
// Notes: every offset and timing count lives here, with the control, range, timing and status fields and the REG_CTRL to REG_RTSOFF reset values
package hdpm_pkg;
   localparam int CLOCK_HZ = 10_000_000;
   localparam int TICK_MS = 20;
   localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
   localparam int BAUD_MIN = 300;
   localparam int BIT_MIN_CYCLES = CLOCK_HZ / BAUD_MIN;

   // register indices
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_STATION = 4'h1;
   localparam logic [3:0] REG_PRI = 4'h2;
   localparam logic [3:0] REG_NRM = 4'h3;
   localparam logic [3:0] REG_TIMING = 4'h4;
   localparam logic [3:0] REG_RTSOFF = 4'h5;
   localparam logic [3:0] REG_STATUS = 4'h6;
   localparam logic [3:0] REG_MSGREQ = 4'h7;

   // control fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_HS_LSB = 2;
   localparam int CTRL_DUP_BIT = 4;
   localparam int CTRL_BAUD_LSB = 5;
   localparam int CTRL_W = 8;
   localparam logic [1:0] MODE_STD_SINGLE = 2'h0;
   localparam logic [1:0] MODE_STD_MULTI = 2'h1;
   localparam logic [1:0] MODE_MSG_DENY = 2'h2;
   localparam logic [1:0] MODE_MSG_ALLOW = 2'h3;
   localparam logic [1:0] HS_NONE = 2'h0;
   localparam logic [1:0] HS_HALF = 2'h1;
   localparam logic [1:0] HS_FULL = 2'h2;
   localparam logic [1:0] HS_485 = 2'h3;

   // range and timing fields
   localparam int LO_LSB = 0;
   localparam int HI_LSB = 8;
   localparam int GROUP_LSB = 16;
   localparam int ACK_LSB = 0;
   localparam int REPLY_LSB = 8;
   localparam int RETRY_LSB = 16;

   // status fields
   localparam int ST_ADDR_LSB = 0;
   localparam int ST_PHASE_BIT = 8;
   localparam int ST_PEND_BIT = 9;
   localparam int ST_DONE_BIT = 10;
   localparam int ST_FAIL_BIT = 11;
   localparam int ST_DUP_BIT = 12;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'hd0;
   localparam logic [7:0] STATION_RST = 8'h01;
   localparam logic [7:0] RANGE_LO_RST = 8'hff;
   localparam logic [7:0] RANGE_HI_RST = 8'h00;
   localparam logic [7:0] GROUP_RST = 8'h00;
   localparam logic [7:0] ACK_RST = 8'h32;
   localparam logic [7:0] REPLY_RST = 8'h05;
   localparam logic [7:0] RETRY_RST = 8'h03;
   localparam logic [15:0] RTSOFF_RST = 16'h0000;

   localparam logic [7:0] ADDR_BROADCAST = 8'hff;
   localparam logic [7:0] RANGE_OFF = 8'hff;

   typedef enum logic [1:0] {HDPM_PKT_POLL, HDPM_PKT_MSG, HDPM_PKT_FWD, HDPM_PKT_REPLY} hdpm_pkt_t;
   typedef enum logic [1:0] {HDPM_RX_ACK, HDPM_RX_EMPTY, HDPM_RX_MSG, HDPM_RX_NAK} hdpm_rx_t;
endpackage : hdpm_pkg

/* File: hdpm_slave_model.sv */
// Purpose: slave stations seen through the packet framer
// Assumes: one frame at a time
// Notes: one queued slave-to-slave message at i_fwd_src
`timescale 1ns/1ps
module hdpm_slave_model (
   input wire logic i_clock, i_nrst, i_tx_valid,
   input wire hdpm_pkg::hdpm_pkt_t i_tx_kind,
   input wire logic [7:0] i_tx_dest, i_fwd_src, i_fwd_dst,
   output logic o_tx_done, o_rx_valid, o_rx_cmd,
   output hdpm_pkg::hdpm_rx_t o_rx_kind,
   output logic [7:0] o_rx_dest, o_rx_src,
   output logic [15:0] o_rx_sig
);
   logic [3:0] cnt = 0, ans = 0;
   logic sent = 0;
   hdpm_pkg::hdpm_pkt_t kind;
   logic [7:0] dst;
   initial {o_tx_done, o_rx_valid, o_rx_cmd, o_rx_dest, o_rx_src, o_rx_sig} = 0;
   initial o_rx_kind = hdpm_pkg::HDPM_RX_ACK;
   always @(posedge i_clock) begin
      o_tx_done <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_dest <= ~o_rx_dest; // idle header lines toggle
      o_rx_src <= ~o_rx_src;
      if (ans > 0) ans <= ans - 1;
      if (!i_nrst) begin
         cnt <= 0;
         ans <= 0;
      end else if (i_tx_valid && !o_tx_done) begin
         cnt <= cnt + 1;
         if (cnt == 4'(2 + $urandom % 4)) begin
            {o_tx_done, cnt, dst, ans} <= {1'b1, 4'h0, i_tx_dest, 4'h2};
            kind <= i_tx_kind;
         end
      end else if (ans == 1) begin
         o_rx_valid <= 1'b1; // answers only after a frame from the master
         o_rx_kind <= hdpm_pkg::HDPM_RX_ACK;
         if (kind == hdpm_pkg::HDPM_PKT_POLL) begin
            o_rx_kind <= hdpm_pkg::HDPM_RX_EMPTY; // nothing queued
            if (dst == i_fwd_src && !sent) begin
               o_rx_kind <= hdpm_pkg::HDPM_RX_MSG;
               {o_rx_dest, o_rx_src} <= {i_fwd_dst, dst};
               {o_rx_cmd, o_rx_sig, sent} <= {1'b1, 16'($urandom), 1'b1};
            end
         end
      end
   end
endmodule : hdpm_slave_model

/* File: hdpm_timer.sv */
// Purpose: down-counter of tick units with a one-cycle expiry pulse
// Assumes: i_tick from a free-running divider
// Notes: the first unit may be short since ticks are not aligned to the load
`timescale 1ns/1ps
module hdpm_timer (
   input wire logic i_clock,
   input wire logic i_nrst,
   input wire logic i_load,
   input wire logic [15:0] i_value,
   input wire logic i_tick,
   output logic o_busy,
   output logic o_expire
);
   logic [15:0] cnt;

   always_ff @(posedge i_clock) begin
      if (!i_nrst) begin
         cnt <= 16'h0000;
         o_busy <= 1'b0;
         o_expire <= 1'b0;
      end else if (i_load) begin
         cnt <= i_value;
         o_busy <= 1'b1;
         o_expire <= 1'b0;
      end else begin
         o_expire <= o_busy && (cnt == 16'h0000);
         if (o_busy && cnt == 16'h0000) begin
            o_busy <= 1'b0;
         end else if (o_busy && i_tick) begin
            cnt <= cnt - 16'h0001;
         end
      end
   end
endmodule : hdpm_timer
